//--- core/xmem_consts.svh
// Constants for the external data memory interface
`ifndef XMEM_CONSTS_SVH
`define XMEM_CONSTS_SVH
`define XM_RAM_BYTES      8192
`define XM_RAM_AW         13
`define XM_PAGE_RESET     8'h00
`define XM_CFG_RESET      8'h03
`define XM_CFG_PORT_BANK_SELECT_BIT 5
`define XM_CFG_MUXN_BIT   4
`define XM_CFG_MODE_HI    3
`define XM_CFG_MODE_LO    2
`define XM_CFG_ALE_HI     1
`define XM_CFG_ALE_LO     0
`define XM_CFG_MASK       8'h3F
`define XM_RAM_LIMIT      17'h0_2000
`endif

//--- core/xmem_pkg.sv
// Types for the external data memory interface
package xmem_pkg;
  typedef enum logic [1:0] {
    MODE_ONCHIP  = 2'b00,
    MODE_SPLIT   = 2'b01,
    MODE_SPLITBS = 2'b10,
    MODE_OFFCHIP = 2'b11
  } mem_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ALEHI = 3'b001,
    ST_ALELO = 3'b011,
    ST_STRB  = 3'b010,
    ST_DONE  = 3'b110
  } bus_state_e;
endpackage

//--- core/xmem_ram.sv
// Single-port on-chip expansion RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module xmem_ram #(
  parameter int AW = 13
) (
  // Clock
  input  wire logic          core_clk,
  // Port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

//--- core/external_data_memory_interface.sv
// External data memory interface with on-chip expansion RAM
`timescale 1ns/1ps
`default_nettype none
`include "xmem_consts.svh"
// Notes on behaviour
// - Eight kilobytes of on-chip RAM sit in the external data space.
// - Accesses go to on-chip RAM unless configured for off-chip.
// - Sixteen-bit form uses the whole data pointer as address.
// - Data pointer readable and writable as high and low bytes.
// - Eight-bit form uses page register high, indirect register low.
// - Page register is eight bits, resets to zero, selects 256-byte window.
// - Bank select bit chooses lower or upper port group.
// - Upper group offered only on the large package variant.
// - Pins claimed only during an off-chip external move.
// - Pins handed back to latches or crossbar when access ends.
// - Drivers of input pins, data during reads, are disabled.
// - Push-pull or open-drain mode is left to port mode registers.
// - Four memory modes selectable by software.
// - Multiplexed or separate bus chosen by a configuration bit.
// - Multiplexed mode shares data and low address on eight pins.
// - Device drives an address latch strobe in multiplexed mode.
// - Latch width bits act only while multiplexed mode is chosen.
module external_data_memory_interface
  import xmem_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1,
  parameter int STRB_CYC  = 2
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Special register port
  input  wire logic        sfrWe,
  input  wire logic [1:0]  sfrSel,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  pageRdata,
  output logic      [7:0]  cfgRdata,
  output logic      [7:0]  dptrHighRdata,
  output logic      [7:0]  dptrLowRdata,
  // External move request from the core
  input  wire logic        moveReq,
  input  wire logic        moveWrite,
  input  wire logic        moveShort,
  input  wire logic [7:0]  indirectReg,
  input  wire logic [7:0]  moveWdata,
  output logic             moveDone,
  output logic      [7:0]  moveRdata,
  // Pin bus towards the selected port group
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic      [7:0]  dataOe,
  output logic      [15:0] addrOut,
  output logic             addrOe,
  output logic             wrStrbN,
  output logic             rdStrbN,
  output logic             aleOut,
  output logic             ctlOe,
  output logic             upperBank
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  page;
    logic [7:0]  cfg;
    logic [15:0] data_pointer;
    bus_state_e  st;
    logic [2:0]  cnt;
    logic [15:0] addr;
    logic        wr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic        done;
    logic [7:0]  dOut;
    logic [7:0]  dOe;
    logic [15:0] aOut;
    logic        aOe;
    logic        wrN;
    logic        rdN;
    logic        ale;
    logic        cOe;
    logic        ramRd;
  } state_s;

  localparam logic [1:0] SEL_PAGE = 2'd0;
  localparam logic [1:0] SEL_CFG  = 2'd1;
  localparam logic [1:0] SEL_DPH  = 2'd2;
  localparam logic [1:0] SEL_DPL  = 2'd3;
  localparam logic [2:0] STRB_N   = 3'(STRB_CYC);

  state_s q, d;
  logic [7:0] dinS1;
  logic [7:0] dinS2;
  logic [7:0] ramRdata;
  logic       ramWe;
  logic [`XM_RAM_AW-1:0] ramAddr;
  logic [7:0] ramWdata;
  logic       moveTake;
  logic       offChip;
  logic [15:0] effAddr;

  // Off-chip decision for an effective address
  function automatic logic goes_off(input logic [1:0] m,
                                    input logic [15:0] a);
    logic below;
    below = {1'b0, a} < `XM_RAM_LIMIT;
    unique case (mem_mode_e'(m))
      MODE_ONCHIP:  goes_off = 1'b0;
      MODE_SPLIT:   goes_off = !below;
      MODE_SPLITBS: goes_off = !below;
      MODE_OFFCHIP: goes_off = 1'b1;
    endcase
  endfunction

  // Latch strobe width in clocks from the two select bits
  function automatic logic [2:0] ale_len(input logic [1:0] s);
    ale_len = {1'b0, s} + 3'd1;
  endfunction

  // ----------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dinS1 <= 8'h00;
      dinS2 <= 8'h00;
    end else begin
      dinS1 <= dataIn;
      dinS2 <= dinS1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ea;
    logic        mux;
    ea  = 16'h0000;
    mux = 1'b0;
    d = q;
    d.done  = 1'b0;
    d.ramRd = 1'b0;
    mux = !q.cfg[`XM_CFG_MUXN_BIT];
    if (sfrWe && q.st == ST_IDLE) begin
      unique case (sfrSel)
        SEL_PAGE: d.page = sfrWdata;
        SEL_CFG:  d.cfg  = sfrWdata & `XM_CFG_MASK;
        SEL_DPH:  d.data_pointer[15:8] = sfrWdata;
        SEL_DPL:  d.data_pointer[7:0]  = sfrWdata;
      endcase
    end
    // Small package has no upper port group
    if (!LARGE_PKG) begin
      d.cfg[`XM_CFG_PORT_BANK_SELECT_BIT] = 1'b0;
    end
    if (q.ramRd) begin
      d.rdat = ramRdata;
      d.done = 1'b1;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (moveTake) begin
          ea = moveShort ? {q.page, indirectReg} : q.data_pointer;
          d.addr = ea;
          d.wr   = moveWrite;
          d.wdat = moveWdata;
          if (goes_off(q.cfg[`XM_CFG_MODE_HI:`XM_CFG_MODE_LO], ea)) begin
            d.cOe  = 1'b1;
            d.aOe  = 1'b1;
            d.aOut = ea;
            if (mux) begin
              d.dOut = ea[7:0];
              d.dOe  = 8'hFF;
              d.ale  = 1'b1;
              d.cnt  = ale_len(q.cfg[`XM_CFG_ALE_HI:`XM_CFG_ALE_LO]);
              d.st   = ST_ALEHI;
            end else begin
              d.dOut = moveWdata;
              d.dOe  = moveWrite ? 8'hFF : 8'h00;
              d.wrN  = !moveWrite;
              d.rdN  = moveWrite;
              d.cnt  = STRB_N;
              d.st   = ST_STRB;
            end
          end else begin
            d.ramRd = 1'b1;
          end
        end
      end
      ST_ALEHI: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd1) begin
          d.ale = 1'b0;
          d.cnt = ale_len(q.cfg[`XM_CFG_ALE_HI:`XM_CFG_ALE_LO]);
          d.st  = ST_ALELO;
        end
      end
      ST_ALELO: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd1) begin
          d.dOut = q.wdat;
          d.dOe  = q.wr ? 8'hFF : 8'h00;
          d.wrN  = !q.wr;
          d.rdN  = q.wr;
          d.cnt  = STRB_N;
          d.st   = ST_STRB;
        end
      end
      ST_STRB: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd1) begin
          d.wrN = 1'b1;
          d.rdN = 1'b1;
          d.st  = ST_DONE;
        end
      end
      ST_DONE: begin
        d.cOe  = 1'b0;
        d.aOe  = 1'b0;
        d.dOe  = 8'h00;
        // Pins lag two clocks through the synchroniser, so this byte
        // was sampled one clock before the read strobe rose; needs a
        // strobe of two clocks or more
        if (!q.wr) begin
          d.rdat = dinS2;
        end
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.page  <= `XM_PAGE_RESET;
      q.cfg   <= `XM_CFG_RESET;
      q.st    <= ST_IDLE;
      q.wrN   <= 1'b1;
      q.rdN   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  // A request still high while done shows is the one just served,
  // so it must not start a second access
  assign moveTake = q.st == ST_IDLE && moveReq && !q.ramRd && !q.done;
  assign effAddr  = moveShort ? {q.page, indirectReg} : q.data_pointer;
  assign offChip  = goes_off(q.cfg[`XM_CFG_MODE_HI:`XM_CFG_MODE_LO],
                             effAddr);

  // ----------------------------------------------------------------
  // On-chip RAM
  // ----------------------------------------------------------------
  assign ramWe    = moveTake && moveWrite && !offChip;
  assign ramAddr  = moveShort ? {q.page[4:0], indirectReg}
                              : q.data_pointer[`XM_RAM_AW-1:0];
  assign ramWdata = moveWdata;

  xmem_ram #(
    .AW (`XM_RAM_AW)
  ) u_ram (
    .core_clk (core_clk),
    .we       (ramWe),
    .addr     (ramAddr),
    .wdata    (ramWdata),
    .rdata    (ramRdata)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pageRdata     = q.page;
  assign cfgRdata      = q.cfg;
  assign dptrHighRdata = q.data_pointer[15:8];
  assign dptrLowRdata  = q.data_pointer[7:0];
  assign moveDone      = q.done;
  assign moveRdata     = q.rdat;
  assign dataOut       = q.dOut;
  assign dataOe        = q.dOe;
  assign addrOut       = q.aOut;
  assign addrOe        = q.aOe;
  assign wrStrbN       = q.wrN;
  assign rdStrbN       = q.rdN;
  assign aleOut        = q.ale;
  assign ctlOe         = q.cOe;
  assign upperBank     = q.cfg[`XM_CFG_PORT_BANK_SELECT_BIT];
endmodule
`default_nettype wire

//--- tb/xmem_properties.sv
// Concurrent checks on the external memory interface ports
`timescale 1ns/1ps
`default_nettype none
module xmem_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Core side
  input wire logic       moveReq,
  input wire logic       moveDone,
  input wire logic [7:0] cfgRdata,
  input wire logic [7:0] pageRdata,
  // Pin side
  input wire logic [7:0] dataOe,
  input wire logic       ctlOe,
  input wire logic       wrStrbN,
  input wire logic       rdStrbN,
  input wire logic       aleOut,
  input wire logic       upperBank
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_low2;
    !rdStrbN ##1 !rdStrbN;
  endsequence
  reset_vals_a: assert property (
    $rose(rstn) |-> pageRdata == 8'h00 && cfgRdata == 8'h03)
    else $error("bad reset values");
  idle_pins_a: assert property (
    !moveReq && !$past(moveReq) |-> !ctlOe)
    else $error("pins claimed while idle");
  read_drv_off_a: assert property (
    !rdStrbN |-> dataOe == 8'h00)
    else $error("data driven during read");
  write_drv_on_a: assert property (
    !wrStrbN |-> ctlOe && dataOe == 8'hFF)
    else $error("data not driven during write");
  strobe_excl_a: assert property (
    wrStrbN || rdStrbN)
    else $error("both strobes low");
  onchip_quiet_a: assert property (
    cfgRdata[3:2] == 2'b00 |-> !ctlOe)
    else $error("pins claimed in on-chip mode");
  bank_sel_a: assert property (
    upperBank == cfgRdata[5] && (!ctlOe || $stable(upperBank)))
    else $error("bank select mismatch");
  ale_mux_a: assert property (
    aleOut |-> !cfgRdata[4])
    else $error("latch strobe outside multiplexed mode");
  offchip_start_a: assert property (
    $rose(moveReq) && cfgRdata[3:2] == 2'b11 |-> ##[1:2] ctlOe)
    else $error("off-chip access did not claim pins");
  onchip_done_a: assert property (
    $rose(moveReq) && cfgRdata[3:2] == 2'b00 |-> ##[1:3] moveDone)
    else $error("on-chip access late");
  done_pulse_a: assert property (
    moveDone |=> !moveDone)
    else $error("done longer than one cycle");
  strobe_width_a: assert property (
    $fell(rdStrbN) |-> s_low2 ##1 rdStrbN)
    else $error("read strobe width wrong");
endmodule
bind external_data_memory_interface xmem_properties i_xmem_properties (
  .core_clk(core_clk), .rstn(rstn), .moveReq(moveReq), .moveDone(moveDone),
  .cfgRdata(cfgRdata), .pageRdata(pageRdata), .dataOe(dataOe),
  .ctlOe(ctlOe), .wrStrbN(wrStrbN), .rdStrbN(rdStrbN), .aleOut(aleOut),
  .upperBank(upperBank));
`default_nettype wire

//--- tb/xmem_sram_model.sv
// Behavioural off-chip SRAM on the pin bus
`timescale 1ns/1ps
`default_nettype none
module xmem_sram_model (
  // Pin bus from the interface
  input  wire logic [15:0] addrOut,
  input  wire logic [7:0]  dataOut,
  input  wire logic        addrOe,
  input  wire logic        wrStrbN,
  input  wire logic        rdStrbN,
  input  wire logic        aleOut,
  input  wire logic        muxMode,
  // Read data back to the pins
  output logic      [7:0]  dataIn
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lowLatch = 8'h00;
  logic [15:0] adr;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(negedge aleOut) lowLatch = dataOut;
  assign adr = muxMode ? {addrOut[15:8], lowLatch} : addrOut;
  // Pins are push-pull, so strobe edges are taken as driven
  always @(posedge wrStrbN) begin
    if (addrOe === 1'b1) mem[adr] = dataOut;
  end
  // Released data lines float to the parked latch level, all ones
  assign dataIn = (rdStrbN === 1'b0) ? mem[adr] : 8'hFF;
endmodule
`default_nettype wire

//--- tb/external_data_memory_interface_bench.sv
// Directed bench for the external data memory interface
`timescale 1ns/1ps
`default_nettype none
module external_data_memory_interface_bench;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sfrWe = 1'b0;
  logic [1:0]  sfrSel = 2'b00;
  logic [7:0]  sfrWdata = 8'h00;
  logic        moveReq = 1'b0;
  logic        moveWrite = 1'b0;
  logic        moveShort = 1'b0;
  logic [7:0]  indirectReg = 8'h00;
  logic [7:0]  moveWdata = 8'h00;
  logic        muxMode = 1'b0;
  logic [7:0]  pageRdata, cfgRdata, dptrHighRdata, dptrLowRdata;
  logic [7:0]  moveRdata, dataIn, dataOut, dataOe, rd;
  logic [15:0] addrOut;
  logic        moveDone, addrOe, wrStrbN, rdStrbN, aleOut, ctlOe, upperBank;
  int          n_fail = 0;
  int          checks = 0;
  always #2.5 core_clk = ~core_clk;
  external_data_memory_interface i_external_data_memory_interface (
    .core_clk(core_clk), .rstn(rstn), .sfrWe(sfrWe), .sfrSel(sfrSel),
    .sfrWdata(sfrWdata), .pageRdata(pageRdata), .cfgRdata(cfgRdata),
    .dptrHighRdata(dptrHighRdata), .dptrLowRdata(dptrLowRdata),
    .moveReq(moveReq), .moveWrite(moveWrite), .moveShort(moveShort),
    .indirectReg(indirectReg), .moveWdata(moveWdata), .moveDone(moveDone),
    .moveRdata(moveRdata), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .addrOut(addrOut), .addrOe(addrOe), .wrStrbN(wrStrbN),
    .rdStrbN(rdStrbN), .aleOut(aleOut), .ctlOe(ctlOe),
    .upperBank(upperBank));
  xmem_sram_model i_xmem_sram_model (
    .addrOut(addrOut), .dataOut(dataOut), .addrOe(addrOe),
    .wrStrbN(wrStrbN), .rdStrbN(rdStrbN), .aleOut(aleOut),
    .muxMode(muxMode), .dataIn(dataIn));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sfr_wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge core_clk);
    sfrWe <= 1'b1;
    sfrSel <= s;
    sfrWdata <= d;
    @(posedge core_clk);
    sfrWe <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic acc(input logic w, sh, input logic [15:0] a,
                     input logic [7:0] d);
    int i;
    if (sh) sfr_wr(2'd0, a[15:8]);
    else sfr_wr(2'd2, a[15:8]);
    if (!sh) sfr_wr(2'd3, a[7:0]);
    @(posedge core_clk);
    moveReq <= 1'b1;
    moveWrite <= w;
    moveShort <= sh;
    indirectReg <= a[7:0];
    moveWdata <= d;
    for (i = 0; i < 100; i++) begin
      @(negedge core_clk);
      if (moveDone === 1'b1) break;
    end
    if (i == 100) begin
      n_fail++;
      finish_test();
    end
    rd = moveRdata;
    @(posedge core_clk);
    moveReq <= 1'b0;
    @(negedge core_clk);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk("page", 8'h00, pageRdata);
    chk("cfg", 8'h03, cfgRdata);
    chk("data_pointer", 16'h0000, {dptrHighRdata, dptrLowRdata});
    sfr_wr(2'd1, 8'hFF);
    chk("cfg mask", 8'h3F, cfgRdata);
    chk("bank", 1'b1, upperBank);
    $display("test registers done");
    sfr_wr(2'd1, 8'h10);
    acc(1'b1, 1'b0, 16'h1234, 8'hA5);
    chk("data_pointer", 16'h1234, {dptrHighRdata, dptrLowRdata});
    acc(1'b0, 1'b1, 16'h1234, 8'h00);
    chk("page", 8'h12, pageRdata);
    chk("short read", 8'hA5, rd);
    acc(1'b0, 1'b0, 16'hF234, 8'h00);
    chk("alias", 8'hA5, rd);
    $display("test on-chip done");
    for (int m = 1; m < 3; m++) begin
      sfr_wr(2'd1, {4'h1, 2'(m), 2'b00});
      acc(1'b1, 1'b0, 16'h1FFF, 8'(8'h11 + m));
      acc(1'b1, 1'b0, 16'h2000, 8'(8'h21 + m));
      acc(1'b0, 1'b0, 16'h1FFF, 8'h00);
      chk("split low", 8'(8'h11 + m), rd);
      chk("pins low", 8'h00, i_xmem_sram_model.mem[16'h1FFF]);
      chk("pins high", 8'(8'h21 + m),
          i_xmem_sram_model.mem[16'h2000]);
      acc(1'b0, 1'b0, 16'h2000, 8'h00);
      chk("split high", 8'(8'h21 + m), rd);
      chk("released", 1'b0, ctlOe);
    end
    sfr_wr(2'd1, 8'h1C);
    acc(1'b1, 1'b1, 16'h0040, 8'h5A);
    chk("off-chip short", 8'h5A,
        i_xmem_sram_model.mem[16'h0040]);
    muxMode <= 1'b1;
    sfr_wr(2'd1, 8'h0F);
    chk("bank low", 1'b0, upperBank);
    acc(1'b1, 1'b0, 16'h4321, 8'h77);
    chk("mux write", 8'h77, i_xmem_sram_model.mem[16'h4321]);
    acc(1'b0, 1'b0, 16'h4321, 8'h00);
    chk("mux read", 8'h77, rd);
    $display("test off-chip done");
    finish_test();
  end
endmodule
`default_nettype wire
